// >>> mtmon_monitor.v
`timescale 1ns/1ps
`include "mtmon_defs.vh"
module mtmon_monitor
#(
   parameter [6:0] SLAVE_ADDR = 7'h4c,
   // arbitrary value
   parameter [7:0] MAKER_ID = 8'h3c,
   parameter [19:0] TIMEOUT_CYC =
      `MTMON_BUS_TIMEOUT_US * `MTMON_CLK_KHZ / 1000,
   parameter [16:0] FAULT_CYC =
      `MTMON_FAULT_TIME_US * `MTMON_CLK_KHZ / 1000
)
(
   // clock and reset
   input wire sys_clk,
   input wire rst,
   // smbus pins
   input wire scl_in,
   input wire sda_in,
   output wire sda_out,
   output reg sda_oe,
   // alarm pins
   output wire alert_out,
   output reg alert_oe,
   output wire overtemp_out,
   output reg overtemp_oe,
   // converter
   output wire adc_start,
   output wire [2:0] adc_channel,
   input wire adc_done,
   input wire [11:0] adc_temp,
   input wire adc_open,
   input wire adc_short
);

localparam [2:0] S_IDLE = 3'h0;
localparam [2:0] S_ADDR = 3'h1;
localparam [2:0] S_AACK = 3'h2;
localparam [2:0] S_WBYTE = 3'h3;
localparam [2:0] S_WACK = 3'h4;
localparam [2:0] S_RBYTE = 3'h5;
localparam [2:0] S_RACK = 3'h6;

wire scl_s;
wire sda_s;
reg scl_d;
reg sda_d;
reg [2:0] state;
reg [3:0] cnt;
reg [7:0] shreg;
reg [7:0] tx;
reg rw;
reg first;
reg more;
reg [19:0] low_cnt;
reg cmd_stb;
reg wr_stb;
reg rd_stb;
reg [7:0] ptr;
reg [7:0] rd_data;
reg [7:0] temp [0:4];
reg [7:0] alim [0:4];
reg [2:0] frac1;
reg [7:0] olim1;
reg [7:0] olim4;
reg [7:0] ctl1;
reg [7:0] ctl2;
reg [7:0] ctl3;
reg [7:0] st1;
reg [7:0] st2;
reg [7:0] st3;
reg lock;
reg [19:0] lock_cnt;
reg srst;
reg [7:0] al_set;
reg [7:0] ot_set;
reg [7:0] ot_clr;
reg [7:0] fl_set;
reg [7:0] fl_clr;
integer i;

wire res_valid;
wire [2:0] res_channel;
wire [7:0] res_high;
wire [2:0] res_frac;
wire res_open;
wire res_fault;

assign sda_out = 1'b0;
assign alert_out = 1'b0;
assign overtemp_out = 1'b0;

// ----------------------------------------------------------------
// pin synchronisers and bus conditions
// ----------------------------------------------------------------
mtmon_sync #(.W(2)) u_sync
(
   .sys_clk(sys_clk),
   .rst(rst),
   .d({scl_in, sda_in}),
   .q({scl_s, sda_s})
);

always @(posedge sys_clk or posedge rst)
begin
   if (rst)
   begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
   end
   else
   begin
      scl_d <= scl_s;
      sda_d <= sda_s;
   end
end

wire start_c = scl_s && scl_d && sda_d && !sda_s;
wire stop_c = scl_s && scl_d && !sda_d && sda_s;
wire scl_rise = scl_s && !scl_d;
wire scl_fall = !scl_s && scl_d;
wire bus_tmo = !ctl1[`MTMON_CTL1_TMO_DIS] && (state != S_IDLE) &&
               (low_cnt == TIMEOUT_CYC - 20'h0_0001);

// ----------------------------------------------------------------
// smbus slave
// ----------------------------------------------------------------
always @(posedge sys_clk or posedge rst)
begin
   if (rst)
   begin
      state <= S_IDLE;
      cnt <= 4'h0;
      shreg <= 8'h00;
      tx <= 8'h00;
      rw <= 1'b0;
      first <= 1'b0;
      more <= 1'b0;
      low_cnt <= 20'h0_0000;
      sda_oe <= 1'b0;
      cmd_stb <= 1'b0;
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
   end
   else
   begin
      cmd_stb <= 1'b0;
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      low_cnt <= scl_s ? 20'h0_0000 : low_cnt + 20'h0_0001;
      if (stop_c || bus_tmo)
      begin
         state <= S_IDLE;
         sda_oe <= 1'b0;
      end
      else if (start_c)
      begin
         state <= S_ADDR;
         cnt <= 4'h0;
         sda_oe <= 1'b0;
      end
      else if (scl_rise)
      begin
         case (state)
            S_ADDR, S_WBYTE:
            begin
               shreg <= {shreg[6:0], sda_s};
               cnt <= cnt + 4'h1;
            end
            S_RBYTE: cnt <= cnt + 4'h1;
            S_RACK: more <= !sda_s;
            default: ;
         endcase
      end
      else if (scl_fall)
      begin
         case (state)
            S_ADDR:
               if (cnt == 4'h8)
               begin
                  if (shreg[7:1] == SLAVE_ADDR)
                  begin
                     rw <= shreg[0];
                     sda_oe <= 1'b1;
                     state <= S_AACK;
                  end
                  else
                     state <= S_IDLE;
               end
            S_AACK:
            begin
               cnt <= 4'h0;
               first <= 1'b1;
               if (rw)
               begin
                  tx <= {rd_data[6:0], 1'b0};
                  sda_oe <= !rd_data[7];
                  rd_stb <= 1'b1;
                  state <= S_RBYTE;
               end
               else
               begin
                  sda_oe <= 1'b0;
                  state <= S_WBYTE;
               end
            end
            S_WBYTE:
               if (cnt == 4'h8)
               begin
                  sda_oe <= 1'b1;
                  state <= S_WACK;
                  first <= 1'b0;
                  if (first)
                     cmd_stb <= 1'b1;
                  else
                     wr_stb <= 1'b1;
               end
            S_WACK:
            begin
               sda_oe <= 1'b0;
               cnt <= 4'h0;
               state <= S_WBYTE;
            end
            S_RBYTE:
               if (cnt == 4'h8)
               begin
                  sda_oe <= 1'b0;
                  state <= S_RACK;
               end
               else
               begin
                  sda_oe <= !tx[7];
                  tx <= {tx[6:0], 1'b0};
               end
            S_RACK:
               if (more)
               begin
                  cnt <= 4'h0;
                  tx <= {rd_data[6:0], 1'b0};
                  sda_oe <= !rd_data[7];
                  rd_stb <= 1'b1;
                  state <= S_RBYTE;
               end
               else
                  state <= S_IDLE;
            default: state <= S_IDLE;
         endcase
      end
   end
end

// ----------------------------------------------------------------
// read mux
// ----------------------------------------------------------------
always @*
begin
   case (ptr)
      `MTMON_REG_R1_HIGH: rd_data = temp[1];
      `MTMON_REG_R2_TEMP: rd_data = temp[2];
      `MTMON_REG_R3_TEMP: rd_data = temp[3];
      `MTMON_REG_R4_TEMP: rd_data = temp[4];
      `MTMON_REG_LOCAL_TEMP: rd_data = temp[0];
      `MTMON_REG_R1_FRAC: rd_data = {frac1, 5'h00};
      `MTMON_REG_MAKER_ID: rd_data = MAKER_ID;
      `MTMON_REG_R1_ALIM: rd_data = alim[1];
      `MTMON_REG_R2_ALIM: rd_data = alim[2];
      `MTMON_REG_R3_ALIM: rd_data = alim[3];
      `MTMON_REG_R4_ALIM: rd_data = alim[4];
      `MTMON_REG_LOCAL_ALIM: rd_data = alim[0];
      `MTMON_REG_R1_OLIM: rd_data = olim1;
      `MTMON_REG_R4_OLIM: rd_data = olim4;
      `MTMON_REG_CTL1: rd_data = ctl1;
      `MTMON_REG_CTL2: rd_data = ctl2;
      `MTMON_REG_CTL3: rd_data = ctl3;
      `MTMON_REG_ALERT_FLAGS: rd_data = st1;
      `MTMON_REG_OVT_FLAGS: rd_data = st2;
      `MTMON_REG_FAULT_FLAGS: rd_data = st3;
      default: rd_data = 8'h00;
   endcase
end

// ----------------------------------------------------------------
// conversion results to flags
// ----------------------------------------------------------------
wire [2:0] chm1 = res_channel - 3'h1;
wire ovt_ch = (res_channel == 3'h1) || (res_channel == 3'h4);
wire [7:0] olim = (res_channel == 3'h4) ? olim4 : olim1;
wire [7:0] obit = (res_channel == 3'h4) ? (8'h01 << `MTMON_OVT_R4_BIT) :
                  (8'h01 << `MTMON_OVT_R1_BIT);

always @*
begin
   al_set = 8'h00;
   ot_set = 8'h00;
   ot_clr = 8'h00;
   fl_set = 8'h00;
   fl_clr = 8'h00;
   if (res_valid)
   begin
      if (!res_open && (res_high > alim[res_channel]))
      begin
         if (res_channel == 3'h0)
            al_set[`MTMON_LOCAL_BIT] = 1'b1;
         else
            al_set[chm1] = 1'b1;
      end
      if (ovt_ch && !res_open && (res_high > olim))
         ot_set = obit;
      if (ovt_ch && ({1'b0, res_high} + `MTMON_OVT_HYST < {1'b0, olim}))
         ot_clr = obit;
      if (res_channel != 3'h0)
      begin
         if (res_fault)
            fl_set[chm1] = 1'b1;
         else
            fl_clr[chm1] = 1'b1;
      end
   end
end

function [7:0] alim_por;
   input [2:0] c;
   begin
      case (c)
         3'h1: alim_por = `MTMON_POR_R1_ALIM;
         3'h2: alim_por = `MTMON_POR_R2_ALIM;
         3'h3: alim_por = `MTMON_POR_R3_ALIM;
         3'h4: alim_por = `MTMON_POR_R4_ALIM;
         default: alim_por = `MTMON_POR_LOCAL_ALIM;
      endcase
   end
endfunction

task por_all;
   begin
      ptr <= 8'h00;
      for (i = 0; i < 5; i = i + 1)
      begin
         temp[i] <= `MTMON_POR_TEMP;
         alim[i] <= alim_por(i[2:0]);
      end
      frac1 <= 3'h0;
      olim1 <= `MTMON_POR_R1_OLIM;
      olim4 <= `MTMON_POR_R4_OLIM;
      ctl1 <= `MTMON_POR_CTL;
      ctl2 <= `MTMON_POR_CTL;
      ctl3 <= `MTMON_POR_CTL;
      st1 <= 8'h00;
      st2 <= 8'h00;
      st3 <= 8'h00;
      lock <= 1'b0;
      lock_cnt <= 20'h0_0000;
   end
endtask

// ----------------------------------------------------------------
// register file
// ----------------------------------------------------------------
always @(posedge sys_clk or posedge rst)
begin
   if (rst)
   begin
      por_all;
      srst <= 1'b0;
   end
   else if (srst)
   begin
      por_all;
      srst <= 1'b0;
   end
   else
   begin
      srst <= 1'b0;
      if (cmd_stb)
         ptr <= shreg;
      if (wr_stb)
      begin
         case (ptr)
            `MTMON_REG_R1_ALIM: alim[1] <= shreg;
            `MTMON_REG_R2_ALIM: alim[2] <= shreg;
            `MTMON_REG_R3_ALIM: alim[3] <= shreg;
            `MTMON_REG_R4_ALIM: alim[4] <= shreg;
            `MTMON_REG_LOCAL_ALIM: alim[0] <= shreg;
            `MTMON_REG_R1_OLIM: olim1 <= shreg;
            `MTMON_REG_R4_OLIM: olim4 <= shreg;
            `MTMON_REG_CTL1:
            begin
               ctl1 <= shreg & 8'hbf;
               srst <= shreg[`MTMON_CTL1_SRST];
            end
            `MTMON_REG_CTL2: ctl2 <= shreg;
            `MTMON_REG_CTL3: ctl3 <= shreg;
            default: ;
         endcase
      end
      if (res_valid)
      begin
         if (res_channel == 3'h1)
         begin
            frac1 <= res_frac;
            if (!lock)
               temp[1] <= res_high;
         end
         else
            temp[res_channel] <= res_high;
      end
      // set wins over read clear
      if (rd_stb && (ptr == `MTMON_REG_ALERT_FLAGS))
         st1 <= al_set;
      else
         st1 <= st1 | al_set;
      st2 <= (st2 & ~ot_clr) | ot_set;
      st3 <= (st3 & ~fl_clr) | fl_set;
      // low byte read freezes the high byte
      if (rd_stb && (ptr == `MTMON_REG_R1_FRAC))
      begin
         lock <= 1'b1;
         lock_cnt <= 20'h0_0000;
      end
      else if (lock)
      begin
         lock_cnt <= lock_cnt + 20'h0_0001;
         if ((rd_stb && (ptr == `MTMON_REG_R1_HIGH)) ||
             (lock_cnt == TIMEOUT_CYC - 20'h0_0001))
            lock <= 1'b0;
      end
   end
end

// ----------------------------------------------------------------
// alarm pins
// ----------------------------------------------------------------
always @(posedge sys_clk or posedge rst)
begin
   if (rst)
   begin
      alert_oe <= 1'b0;
      overtemp_oe <= 1'b0;
   end
   else
   begin
      alert_oe <= |(st1 & ~ctl2 & `MTMON_ALERT_SRC);
      overtemp_oe <= |(st2 & ~ctl3 & `MTMON_OVT_SRC);
   end
end

// ----------------------------------------------------------------
// conversion sequencer
// ----------------------------------------------------------------
mtmon_seq #(.FAULT_CYC(FAULT_CYC)) u_seq
(
   .sys_clk(sys_clk),
   .rst(rst),
   .run(!ctl1[`MTMON_CTL1_STOP]),
   .fast(ctl1[`MTMON_CTL1_FAST]),
   .adc_start(adc_start),
   .adc_channel(adc_channel),
   .adc_done(adc_done),
   .adc_temp(adc_temp),
   .adc_open(adc_open),
   .adc_short(adc_short),
   .res_valid(res_valid),
   .res_channel(res_channel),
   .res_high(res_high),
   .res_frac(res_frac),
   .res_open(res_open),
   .res_fault(res_fault)
);

endmodule // mtmon_monitor

// >>> mtmon_defs.vh
`ifndef MTMON_DEFS_VH
`define MTMON_DEFS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define MTMON_REG_LOCAL_TEMP 8'h07
`define MTMON_REG_R1_HIGH 8'h01
`define MTMON_REG_R2_TEMP 8'h02
`define MTMON_REG_R3_TEMP 8'h03
`define MTMON_REG_R4_TEMP 8'h04
`define MTMON_REG_R1_FRAC 8'h09
`define MTMON_REG_MAKER_ID 8'h0a
`define MTMON_REG_R1_ALIM 8'h11
`define MTMON_REG_R2_ALIM 8'h12
`define MTMON_REG_R3_ALIM 8'h13
`define MTMON_REG_R4_ALIM 8'h14
`define MTMON_REG_LOCAL_ALIM 8'h17
`define MTMON_REG_R1_OLIM 8'h21
`define MTMON_REG_R4_OLIM 8'h24
`define MTMON_REG_CTL1 8'h41
`define MTMON_REG_CTL2 8'h42
`define MTMON_REG_CTL3 8'h43
`define MTMON_REG_ALERT_FLAGS 8'h44
`define MTMON_REG_OVT_FLAGS 8'h45
`define MTMON_REG_FAULT_FLAGS 8'h46

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define MTMON_POR_TEMP 8'h00
`define MTMON_POR_LOCAL_ALIM 8'h5a
`define MTMON_POR_R1_ALIM 8'h6e
`define MTMON_POR_R2_ALIM 8'h7f
`define MTMON_POR_R3_ALIM 8'h64
`define MTMON_POR_R4_ALIM 8'h64
`define MTMON_POR_R1_OLIM 8'h6e
`define MTMON_POR_R4_OLIM 8'h7f
`define MTMON_POR_CTL 8'h00

// ----------------------------------------------------------------
// field positions and encodings
// ----------------------------------------------------------------
`define MTMON_CTL1_STOP 7
`define MTMON_CTL1_SRST 6
`define MTMON_CTL1_TMO_DIS 5
`define MTMON_CTL1_FAST 4
`define MTMON_LOCAL_BIT 6
`define MTMON_ALERT_SRC 8'h4f
`define MTMON_OVT_SRC 8'h09
`define MTMON_OVT_R1_BIT 0
`define MTMON_OVT_R4_BIT 3
`define MTMON_TEMP_MAX 8'h7f
`define MTMON_TEMP_FAULT 8'hff
`define MTMON_OVT_HYST 9'h004

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define MTMON_CLK_KHZ 20000
`define MTMON_BUS_TIMEOUT_US 37000
`define MTMON_FAULT_TIME_US 4000

`endif

// >>> mtmon_sync.v
`timescale 1ns/1ps
module mtmon_sync
#(
   parameter W = 2
)
(
   // clock and reset
   input wire sys_clk,
   input wire rst,
   // async in, synced out
   input wire [W-1:0] d,
   output reg [W-1:0] q
);

reg [W-1:0] meta;

always @(posedge sys_clk or posedge rst)
begin
   if (rst)
   begin
      meta <= {W{1'b1}};
      q <= {W{1'b1}};
   end
   else
   begin
      meta <= d;
      q <= meta;
   end
end

endmodule // mtmon_sync

// >>> mtmon_seq.v
`timescale 1ns/1ps
`include "mtmon_defs.vh"
module mtmon_seq
#(
   parameter [16:0] FAULT_CYC =
      `MTMON_FAULT_TIME_US * `MTMON_CLK_KHZ / 1000
)
(
   // clock and reset
   input wire sys_clk,
   input wire rst,
   // control
   input wire run,
   input wire fast,
   // converter
   output reg adc_start,
   output reg [2:0] adc_channel,
   input wire adc_done,
   input wire [11:0] adc_temp,
   input wire adc_open,
   input wire adc_short,
   // results
   output reg res_valid,
   output reg [2:0] res_channel,
   output reg [7:0] res_high,
   output reg [2:0] res_frac,
   output reg res_open,
   output reg res_fault
);

reg busy;
reg [2:0] step;
reg [16:0] fcnt;
wire fault_hit = adc_open && (fcnt == FAULT_CYC - 17'h0_0001);
wire bad = fault_hit || adc_open || adc_short;

// channel 0 is local, 1..4 remote
function [2:0] seq_ch;
   input f;
   input [2:0] s;
   begin
      if (f)
         seq_ch = !s[0] ? 3'h1 : (s[2:1] == 2'h3) ? 3'h0 :
                  {1'b0, s[2:1]} + 3'h2;
      else
         seq_ch = (s >= 3'h4) ? 3'h0 : s + 3'h1;
   end
endfunction

// ----------------------------------------------------------------
// conversion sequence
// ----------------------------------------------------------------
always @(posedge sys_clk or posedge rst)
begin
   if (rst)
   begin
      busy <= 1'b0;
      step <= 3'h0;
      fcnt <= 17'h0_0000;
      adc_start <= 1'b0;
      adc_channel <= 3'h1;
      res_valid <= 1'b0;
      res_channel <= 3'h0;
      res_high <= 8'h00;
      res_frac <= 3'h0;
      res_open <= 1'b0;
      res_fault <= 1'b0;
   end
   else
   begin
      adc_start <= 1'b0;
      res_valid <= 1'b0;
      if (!run)
         busy <= 1'b0;
      else if (!busy)
      begin
         adc_start <= 1'b1;
         adc_channel <= seq_ch(fast, step);
         busy <= 1'b1;
         fcnt <= 17'h0_0000;
      end
      else if (adc_done || fault_hit)
      begin
         busy <= 1'b0;
         res_valid <= 1'b1;
         res_channel <= adc_channel;
         res_open <= fault_hit || adc_open;
         res_fault <= bad;
         if (bad)
         begin
            res_high <= `MTMON_TEMP_FAULT;
            res_frac <= 3'h7;
         end
         else if (adc_temp[11])
         begin
            res_high <= 8'h00;
            res_frac <= 3'h0;
         end
         else if (adc_temp[10])
         begin
            res_high <= `MTMON_TEMP_MAX;
            res_frac <= 3'h7;
         end
         else
         begin
            res_high <= adc_temp[10:3];
            res_frac <= adc_temp[2:0];
         end
         if (fast)
            step <= step + 3'h1;
         else
            step <= (step >= 3'h4) ? 3'h0 : step + 3'h1;
      end
      else
         fcnt <= adc_open ? fcnt + 17'h0_0001 : 17'h0_0000;
   end
end

endmodule // mtmon_seq

// >>> mtmon_assertions.sv
`timescale 1ns/1ps
module mtmon_assertions
#(
   parameter [16:0] FAULT_CYC = 17'h1_3880
)
(
   // clock and reset
   input wire sys_clk,
   input wire rst,
   // smbus pins
   input wire scl_in,
   input wire sda_in,
   input wire sda_out,
   input wire sda_oe,
   // alarm pins
   input wire alert_out,
   input wire alert_oe,
   input wire overtemp_out,
   input wire overtemp_oe,
   // converter
   input wire adc_start,
   input wire [2:0] adc_channel,
   input wire adc_done,
   input wire [11:0] adc_temp,
   input wire adc_open,
   input wire adc_short
);
   localparam [17:0] FAULT_LIM = FAULT_CYC + 18'h0_0008;
   reg [17:0] wait_cnt;

   // ----
   // cycles since the last start or result
   // ----
   always @(posedge sys_clk or posedge rst)
      if (rst)
         wait_cnt <= 18'h0_0000;
      else if (adc_start || adc_done)
         wait_cnt <= 18'h0_0000;
      else if (!wait_cnt[17])
         wait_cnt <= wait_cnt + 18'h0_0001;

   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   AST_SDA_OPEN_DRAIN: assert property (sda_out == 1'b0)
      else $error("data pin drives high");
   AST_SDA_SCL_LOW: assert property (
      $changed(sda_oe) |-> !$past(scl_in))
      else $error("data changed with clock high");
   AST_PINS_OPEN_DRAIN: assert property (!alert_out && !overtemp_out)
      else $error("alarm pin drives high");
   AST_ALERT_AFTER_RESULT: assert property ($rose(alert_oe) |->
      $past(adc_done, 3) && !$past(adc_open, 3))
      else $error("alert rose without a good result");
   AST_OVT_NOT_OPEN: assert property ($rose(overtemp_oe) |->
      !$past(adc_open, 3))
      else $error("overtemp rose on open diode");
   AST_NEXT_START: assert property (adc_done |-> ##2 adc_start)
      else $error("sequence paused after a result");
   AST_START_PULSE: assert property (adc_start |=> !adc_start)
      else $error("start longer than one cycle");
   AST_FAULT_ADVANCE: assert property (
      adc_open |-> wait_cnt <= FAULT_LIM)
      else $error("open channel not skipped");
   AST_CHANNEL_HELD: assert property (
      !adc_start |-> $stable(adc_channel))
      else $error("channel moved without start");

   cover property ($rose(alert_oe));
   cover property ($fell(alert_oe));
   cover property ($rose(overtemp_oe));
   cover property (adc_open && adc_start);
endmodule // mtmon_assertions

bind mtmon_monitor mtmon_assertions #(.FAULT_CYC(FAULT_CYC)) u_mtmon_assertions
(
   .sys_clk(sys_clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe(sda_oe), .alert_out(alert_out),
   .alert_oe(alert_oe), .overtemp_out(overtemp_out),
   .overtemp_oe(overtemp_oe), .adc_start(adc_start),
   .adc_channel(adc_channel), .adc_done(adc_done), .adc_temp(adc_temp),
   .adc_open(adc_open), .adc_short(adc_short)
);

// >>> mtmon_host.sv
`timescale 1ns/1ps
module mtmon_host
#(
   parameter [6:0] ADDR = 7'h4c
)
(
   // bus pins
   output logic scl = 1'b1,
   output logic sda_low = 1'b0,
   input wire sda
);
   int nacks = 0;

   task automatic bit_io(input logic tx, output logic rx);
      sda_low = !tx;
      #100;
      scl = 1'b1;
      #100;
      rx = sda;
      #100;
      scl = 1'b0;
      #100;
   endtask

   task automatic start_c;
      sda_low = 1'b0;
      #100;
      scl = 1'b1;
      #100;
      sda_low = 1'b1;
      #100;
      scl = 1'b0;
      #100;
   endtask

   // ninth bit released: ack from device on writes, nack on reads
   task automatic xfer(input logic [7:0] tx, input logic chk,
                       output logic [7:0] rx);
      logic b;
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(tx[i], b);
         rx[i] = b;
      end
      bit_io(1'b1, b);
      if (chk && b)
         nacks++;
   endtask

   // kind 0 write, 1 read, 2 send, 3 receive byte
   task automatic access(input logic [7:0] cmd, input logic [7:0] wd,
                         input int kind, output logic [7:0] rd);
      logic [7:0] d;
      start_c();
      if (kind != 3)
      begin
         xfer({ADDR, 1'b0}, 1'b1, d);
         xfer(cmd, 1'b1, d);
         if (kind == 0)
            xfer(wd, 1'b1, d);
         if (kind == 1)
            start_c();
      end
      if (kind[0])
      begin
         xfer({ADDR, 1'b1}, 1'b1, d);
         xfer(8'hff, 1'b0, rd);
      end
      sda_low = 1'b1;
      #100;
      scl = 1'b1;
      #100;
      sda_low = 1'b0;
      #200;
   endtask
endmodule // mtmon_host

// >>> test_multichannel_temp_monitor_regs.sv
`timescale 1ns/1ps
module test_multichannel_temp_monitor_regs;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic adc_done = 1'b0;
   logic [11:0] adc_temp = 12'h000;
   logic adc_open = 1'b0;
   logic adc_short = 1'b0;
   bit sh = 1'b0;
   wire scl, sda_low, sda_out, sda_oe, alert_out, alert_oe;
   wire overtemp_out, overtemp_oe, adc_start;
   wire [2:0] adc_channel;
   wire sda = !(sda_low || sda_oe);
   int tv [5];
   bit op [5] = '{0, 0, 0, 0, 1};
   bit hold = 1'b0;
   int cnt = 0;
   int miscompares = 0;
   int n_checks = 0;
   logic [15:0] por [10] = '{16'h116e, 16'h127f, 16'h1364, 16'h1464,
      16'h175a, 16'h216e, 16'h247f, 16'h4100, 16'h4200, 16'h4300};

   mtmon_monitor #(.TIMEOUT_CYC(20'h0_07d0), .FAULT_CYC(17'h0_0032))
   u_mtmon_monitor
   (
      .sys_clk(sys_clk), .rst(rst), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe), .alert_out(alert_out),
      .alert_oe(alert_oe), .overtemp_out(overtemp_out),
      .overtemp_oe(overtemp_oe), .adc_start(adc_start),
      .adc_channel(adc_channel), .adc_done(adc_done), .adc_temp(adc_temp),
      .adc_open(adc_open), .adc_short(adc_short)
   );
   mtmon_host u_mtmon_host (.scl(scl), .sda_low(sda_low), .sda(sda));

   initial
   begin
      forever #25 sys_clk = !sys_clk;
   end

   // ----
   // converter model: open channels never answer
   // ----
   always @(posedge sys_clk)
   begin
      adc_done <= 1'b0;
      adc_temp <= $urandom;
      adc_open <= op[adc_channel];
      adc_short <= sh;
      if (adc_start)
         cnt <= 4;
      else if (cnt > 1)
         cnt <= cnt - 1;
      else if (cnt == 1 && !hold && !op[adc_channel])
      begin
         cnt <= 0;
         adc_done <= 1'b1;
         adc_temp <= tv[adc_channel][11:0];
      end
   end

   function automatic logic [7:0] hi(int t, bit o);
      if (o)
         return 8'hff;
      if (t < 0)
         return 8'h00;
      if (t >= 1024)
         return 8'h7f;
      return t[10:3];
   endfunction

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e,
                     input logic [7:0] m);
      logic [7:0] d;
      @(negedge sys_clk);
      u_mtmon_host.access(a, 8'h00, 1, d);
      chk(d & m, e);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      logic [7:0] d;
      @(negedge sys_clk);
      u_mtmon_host.access(a, v, 0, d);
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial
   begin
      repeat (60000) @(posedge sys_clk);
      miscompares++;
      wrap_up();
   end

   initial
   begin
      logic [7:0] v;
      logic [7:0] old;
      int n;
      void'($urandom(36));
      tv[0] = 200;
      tv[1] = (112 + $urandom % 15) * 8 + $urandom % 8;
      tv[2] = -40;
      tv[3] = 1600;
      tv[4] = 0;
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      foreach (por[i])
         rd(por[i][15:8], por[i][7:0], 8'hff);
      v = $urandom;
      wr(8'h12, v);
      rd(8'h12, v, 8'hff);
      foreach (por[i])
         if (i < 3)
            wr(8'({i[1:0], 2'b10} ^ 8'h07), v);
      rd(8'h05, 8'h00, 8'hff);
      rd(8'h0a, 8'h3c, 8'hff);
      u_mtmon_host.access(8'h17, 8'h00, 2, v);
      u_mtmon_host.access(8'h00, 8'h00, 3, v);
      chk(v, 8'h5a);
      for (int c = 1; c < 5; c++)
         rd(8'(c), hi(tv[c], op[c]), 8'hff);
      rd(8'h07, hi(tv[0], 0), 8'hff);
      rd(8'h46, 8'h08, 8'h0f);
      chk({7'h00, overtemp_oe}, 8'h01);
      for (int p = 0; p < 2; p++)
      begin
         old = hi(tv[1], 0);
         rd(8'h09, {tv[1][2:0], 5'h00}, 8'he0);
         tv[1] = tv[1] ^ 8;
         repeat (p ? 2100 : 100) @(posedge sys_clk);
         rd(8'h01, p ? hi(tv[1], 0) : old, 8'hff);
      end
      chk({7'h00, alert_oe}, 8'h01);
      @(posedge sys_clk);
      hold <= 1'b1;
      rd(8'h44, 8'h05, 8'hff);
      chk({7'h00, alert_oe}, 8'h00);
      @(posedge sys_clk);
      hold <= 1'b0;
      for (n = 0; n < 200 && alert_oe !== 1'b1; n++)
         @(negedge sys_clk);
      chk({7'h00, alert_oe}, 8'h01);
      wr(8'h42, 8'h05);
      rd(8'h44, 8'h00, 8'h00);
      repeat (200) @(negedge sys_clk);
      chk({7'h00, alert_oe}, 8'h00);
      rd(8'h42, 8'h05, 8'hff);
      sh <= 1'b1;
      repeat (200) @(negedge sys_clk);
      rd(8'h02, 8'hff, 8'hff);
      rd(8'h46, 8'h0f, 8'h0f);
      chk(u_mtmon_host.nacks[7:0], 8'h00);
      wrap_up();
   end
endmodule // test_multichannel_temp_monitor_regs
